//--- rtl/sbsc_control.sv
// synchronous burst memory control: cycle decode, burst counter, output path, register slave
//
// Behaviour
// - first enable high with controller strobe low deselects; data pins float.
// - read begins on processor strobe low, or controller strobe low without write.
// - write begins on controller strobe low, processor strobe high, write requested.
// - continue conditions, advance low, no write: read next burst address.
// - continue conditions, advance low, write requested: write next burst address.
// - continue conditions, advance high, no write: read current address again.
// - continue conditions, advance high, write: write current address, counter held.
// - linear order counts upward modulo four, back to start on fifth clock.
// - interleaved order XORs start with step, back to start on fifth clock.
// - floating mode pins mean interleaved, pipelined, awake.
// - global write writes all lanes; byte write writes lanes whose enables low.
// - no write request means read, all four lanes drive.
// - all lanes turn off right after every write is captured.
// - output enable high turns drivers off at once, low only permits reads.
// - flow-through shows read data next cycle; pipelined one cycle later.
// - deselect turns outputs off right after it is captured.
// - sleep request holds the block idle and keeps memory contents.
// - reads with output enable high still step the counter.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sbsc_map.svh"
module sbsc_control
(
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  input  wire logic [`SBSC_ADDR_W-1:0]        sramAddr,
  input  wire sbsc_pkg::sbsc_pins_type        sramPins,
  input  wire sbsc_pkg::sbsc_mode_type        modePins,
  input  wire logic                           output_enable_n,
  input  wire logic [`SBSC_DATA_W-1:0]        dqIn,
  output logic      [`SBSC_DATA_W-1:0]        dqOut,
  output logic      [`SBSC_LANES-1:0]         dqOe,
  input  wire sbsc_pkg::sbsc_axi_req_type     axiReq,
  output sbsc_pkg::sbsc_axi_rsp_type          axiRsp
);
  import sbsc_pkg::*;

  // ==========================================================
  // cycle decode
  logic                     ceTrue;
  logic [3:0]               laneN;
  logic [3:0]               laneWe;
  logic                     wrReq;
  logic                     contNow;
  logic                     deselNow;
  logic                     beginRead;
  logic                     beginWrite;
  logic                     advNow;
  logic                     readNow;
  logic                     writeNow;
  logic                     awake;
  logic                     linearMode;
  logic                     flowMode;
  logic                     ctrlSleep_r;

  always_comb
  begin
    linearMode = ~modePins.burst_order_select_n;
    flowMode   = ~modePins.output_register_select_n;
    awake      = ~(modePins.sleep_request | ctrlSleep_r);
    ceTrue     = sramPins.chip_enable_high & ~sramPins.chip_enable_third_n;
    laneN      = {sramPins.lane3_write_n, sramPins.lane2_write_n,
                  sramPins.lane1_write_n, sramPins.lane0_write_n};
    laneWe     = 4'h0;
    if (!sramPins.global_write_n)
    begin
      laneWe = 4'hf;
    end
    else if (!sramPins.byte_write_n)
    begin
      laneWe = ~laneN;
    end
    wrReq      = |laneWe;
    contNow    = sramPins.controller_addr_strobe_n
                 & (sramPins.processor_addr_strobe_n | sramPins.chip_enable_first_n);
    deselNow   = ~contNow & (sramPins.chip_enable_first_n | ~ceTrue);
    beginRead  = ~contNow & ~sramPins.chip_enable_first_n & ceTrue
                 & (~sramPins.processor_addr_strobe_n | ~wrReq);
    beginWrite = ~contNow & ~sramPins.chip_enable_first_n & ceTrue
                 & sramPins.processor_addr_strobe_n & wrReq;
    advNow     = contNow & ~sramPins.burst_advance_n;
    readNow    = awake & (beginRead | (contNow & ~wrReq));
    writeNow   = awake & (beginWrite | (contNow & wrReq));
  end

  // ==========================================================
  // burst address
  logic [1:0]               curLow;
  logic [1:0]               nextLow;
  logic [1:0]               startLow;
  logic [1:0]               stepLow;
  logic [1:0]               useLow;
  logic [`SBSC_ADDR_W-3:0]  upper_r;
  logic [`SBSC_ADDR_W-1:0]  memAddr;
  logic                     loadNow;

  assign loadNow = awake & (beginRead | beginWrite);

  // dummy reads step too: output enable never reaches the counter
  sbsc_burst_counter u_counter
  (
    .clk        (mclk),
    .rst        (sys_rst),
    .load       (loadNow),
    .advance    (awake & advNow),
    .startIn    (sramAddr[1:0]),
    .linearMode (linearMode),
    .curLow     (curLow),
    .nextLow    (nextLow),
    .startOut   (startLow),
    .stepOut    (stepLow)
  );

  // upper address held for the burst
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      upper_r <= '0;
    end
    else if (loadNow)
    begin
      upper_r <= sramAddr[`SBSC_ADDR_W-1:2];
    end
  end

  always_comb
  begin
    useLow  = advNow ? nextLow : curLow;
    memAddr = loadNow ? sramAddr : {upper_r, useLow};
  end

  // ==========================================================
  // storage
  logic [`SBSC_DATA_W-1:0]  memRdata;

  // write at selected address, lanes from decode
  sbsc_memory u_memory
  (
    .clk       (mclk),
    .addr      (memAddr),
    .writeEn   (writeNow),
    .laneEn    (laneWe),
    .writeData (dqIn),
    .readEn    (readNow),
    .readData  (memRdata)
  );

  // ==========================================================
  // output path
  logic                     readStage_r;
  logic                     drive_r;
  logic                     flowSel_r;
  logic [`SBSC_DATA_W-1:0]  pipeData_r;
  logic                     singleStageDeselect;

  // deselect, write or sleep cut the pipelined read short
  assign singleStageDeselect = ~awake | deselNow | writeNow;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      readStage_r <= 1'h0;
      drive_r     <= 1'h0;
      flowSel_r   <= 1'h0;
    end
    else
    begin
      readStage_r <= readNow;
      flowSel_r   <= flowMode;
      if (flowMode)
      begin
        drive_r <= readNow;
      end
      else
      begin
        drive_r <= readStage_r & ~singleStageDeselect;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pipeData_r <= '0;
    end
    else
    begin
      pipeData_r <= memRdata;
    end
  end

  // flow mode select is registered so it matches the edge that set drive_r
  assign dqOut = flowSel_r ? memRdata : pipeData_r;

  assign dqOe  = {`SBSC_LANES{drive_r & ~output_enable_n}};

  // ==========================================================
  // operation state and access count
  sbsc_state_type           state_r;
  logic [15:0]              accessCount_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_DESELECT;
    end
    else if (!awake)
    begin
      state_r <= ST_SLEEP;
    end
    else if (beginRead)
    begin
      state_r <= ST_BEGIN_READ;
    end
    else if (beginWrite)
    begin
      state_r <= ST_BEGIN_WRITE;
    end
    else if (readNow)
    begin
      state_r <= ST_CONTINUE_READ;
    end
    else if (writeNow)
    begin
      state_r <= ST_CONTINUE_WRITE;
    end
    else
    begin
      state_r <= ST_DESELECT;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      accessCount_r <= 16'h0;
    end
    else if (readNow | writeNow)
    begin
      accessCount_r <= 16'(accessCount_r + 16'h1);
    end
  end

  // ==========================================================
  // register slave
  logic                     awHeld_r;
  logic                     wHeld_r;
  logic [`SBSC_AXI_AW-1:0]  awAddr_r;
  logic [31:0]              wData_r;
  logic [3:0]               wStrb_r;
  logic [31:0]              statusWord;

  always_comb
  begin
    statusWord = 32'h0;
    statusWord[`SBSC_ST_BURST +: 2] = curLow;
    statusWord[`SBSC_ST_ASLEEP]     = ~awake;
    statusWord[`SBSC_ST_DRIVE]      = drive_r;
    statusWord[`SBSC_ST_STATE +: 3] = 3'(state_r);
    statusWord[`SBSC_ST_FLOW]       = flowSel_r;
  end

  // write address and data may come in either order
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awHeld_r       <= 1'h0;
      wHeld_r        <= 1'h0;
      awAddr_r       <= '0;
      wData_r        <= 32'h0;
      wStrb_r        <= 4'h0;
      axiRsp.awready <= 1'h0;
      axiRsp.wready  <= 1'h0;
      axiRsp.bvalid  <= 1'h0;
      axiRsp.bresp   <= `SBSC_RESP_OKAY;
      ctrlSleep_r    <= `SBSC_CTRL_RESET;
    end
    else
    begin
      if (axiReq.awvalid && axiRsp.awready)
      begin
        awHeld_r       <= 1'h1;
        awAddr_r       <= axiReq.awaddr;
        axiRsp.awready <= 1'h0;
      end
      else if (!awHeld_r && !axiRsp.bvalid)
      begin
        axiRsp.awready <= 1'h1;
      end
      if (axiReq.wvalid && axiRsp.wready)
      begin
        wHeld_r       <= 1'h1;
        wData_r       <= axiReq.wdata;
        wStrb_r       <= axiReq.wstrb;
        axiRsp.wready <= 1'h0;
      end
      else if (!wHeld_r && !axiRsp.bvalid)
      begin
        axiRsp.wready <= 1'h1;
      end
      if (awHeld_r && wHeld_r && !axiRsp.bvalid)
      begin
        awHeld_r      <= 1'h0;
        wHeld_r       <= 1'h0;
        axiRsp.bvalid <= 1'h1;
        axiRsp.bresp  <= `SBSC_RESP_OKAY;
        if (awAddr_r == `SBSC_OFF_CTRL)
        begin
          if (wStrb_r[0])
          begin
            ctrlSleep_r <= wData_r[`SBSC_CTRL_SLEEP];
          end
        end
        else if (awAddr_r != `SBSC_OFF_STATUS && awAddr_r != `SBSC_OFF_COUNT)
        begin
          axiRsp.bresp <= `SBSC_RESP_SLVERR;
        end
      end
      else if (axiRsp.bvalid && axiReq.bready)
      begin
        axiRsp.bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      axiRsp.arready <= 1'h0;
      axiRsp.rvalid  <= 1'h0;
      axiRsp.rdata   <= 32'h0;
      axiRsp.rresp   <= `SBSC_RESP_OKAY;
    end
    else if (axiReq.arvalid && axiRsp.arready)
    begin
      axiRsp.arready <= 1'h0;
      axiRsp.rvalid  <= 1'h1;
      axiRsp.rresp   <= `SBSC_RESP_OKAY;
      case (axiReq.araddr)
        `SBSC_OFF_CTRL:   axiRsp.rdata <= {31'h0, ctrlSleep_r};
        `SBSC_OFF_STATUS: axiRsp.rdata <= statusWord;
        `SBSC_OFF_COUNT:  axiRsp.rdata <= {16'h0, accessCount_r};
        default:
        begin
          axiRsp.rdata <= 32'h0;
          axiRsp.rresp <= `SBSC_RESP_SLVERR;
        end
      endcase
    end
    else if (axiRsp.rvalid && axiReq.rready)
    begin
      axiRsp.rvalid  <= 1'h0;
    end
    else if (!axiRsp.rvalid)
    begin
      axiRsp.arready <= 1'h1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_deselect_off: assert property (deselNow |=> !drive_r)
    else $error("drivers still on after deselect");
  a_write_float: assert property (writeNow |=> (dqOe == 4'h0))
    else $error("lanes driven during write");
  a_flow_timing: assert property (flowMode && readNow |=> drive_r)
    else $error("flow-through read not driven next cycle");
  a_pipe_timing: assert property (
      !flowMode && readNow ##1 (!flowMode && !singleStageDeselect) |=> drive_r)
    else $error("pipelined read not driven two cycles on");
  a_oe_gate: assert property (output_enable_n |-> (dqOe == 4'h0))
    else $error("drivers on while output enable high");
  a_burst_load: assert property (loadNow |=> curLow == $past(sramAddr[1:0]))
    else $error("counter not loaded at burst start");
  a_linear_step: assert property (
      awake && advNow && !loadNow && linearMode |=> curLow == 2'($past(curLow) + 2'h1))
    else $error("linear burst step wrong");
  a_inter_step: assert property (
      awake && advNow && !linearMode
      |=> curLow == ($past(startLow) ^ 2'($past(stepLow) + 2'h1)))
    else $error("interleaved burst step wrong");
  a_suspend_hold: assert property (
      awake && contNow && sramPins.burst_advance_n |=> $stable(curLow))
    else $error("counter moved on suspend");
  a_sleep_idle: assert property (!awake |=> !drive_r && state_r == ST_SLEEP)
    else $error("activity while asleep");

  c_burst_four: cover property (loadNow && readNow ##1 (advNow && readNow)[*3]);
  c_write_begin: cover property (awake && beginWrite);
  c_dummy_read: cover property (readNow && output_enable_n ##1 writeNow);
  c_sleep_entry: cover property (awake ##1 !awake);

endmodule

//--- rtl/sbsc_map.svh
// offsets, field positions, sizes and reset values of the burst memory control block
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH

`define SBSC_ADDR_W       16
`define SBSC_DEPTH        65536
`define SBSC_DATA_W       32
`define SBSC_LANES        4
`define SBSC_AXI_AW       8

`define SBSC_OFF_CTRL     8'h00
`define SBSC_OFF_STATUS   8'h04
`define SBSC_OFF_COUNT    8'h08

`define SBSC_CTRL_SLEEP   0
`define SBSC_CTRL_RESET   1'h0
`define SBSC_ST_BURST     0
`define SBSC_ST_ASLEEP    2
`define SBSC_ST_DRIVE     3
`define SBSC_ST_STATE     4
`define SBSC_ST_FLOW      7

`define SBSC_RESP_OKAY    2'h0
`define SBSC_RESP_SLVERR  2'h2

`endif

//--- rtl/sbsc_pkg.sv
// types shared by the burst memory control block
`include "sbsc_map.svh"
package sbsc_pkg;

  typedef struct packed {
    logic chip_enable_first_n;
    logic chip_enable_high;
    logic chip_enable_third_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_n;
    logic lane3_write_n;
    logic lane2_write_n;
    logic lane1_write_n;
    logic lane0_write_n;
  } sbsc_pins_type;

  typedef struct packed {
    logic burst_order_select_n;
    logic output_register_select_n;
    logic sleep_request;
  } sbsc_mode_type;

  typedef struct packed {
    logic                      awvalid;
    logic [`SBSC_AXI_AW-1:0]   awaddr;
    logic                      wvalid;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bready;
    logic                      arvalid;
    logic [`SBSC_AXI_AW-1:0]   araddr;
    logic                      rready;
  } sbsc_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sbsc_axi_rsp_type;

  typedef enum logic [2:0] {
    ST_DESELECT,
    ST_BEGIN_READ,
    ST_BEGIN_WRITE,
    ST_CONTINUE_READ,
    ST_CONTINUE_WRITE,
    ST_SLEEP
  } sbsc_state_type;

endpackage

//--- rtl/sbsc_memory.sv
// byte-lane storage array with registered read data
`timescale 1ns/1ps
`include "sbsc_map.svh"
module sbsc_memory
(
  input  wire logic                      clk,
  input  wire logic [`SBSC_ADDR_W-1:0]   addr,
  input  wire logic                      writeEn,
  input  wire logic [`SBSC_LANES-1:0]    laneEn,
  input  wire logic [`SBSC_DATA_W-1:0]   writeData,
  input  wire logic                      readEn,
  output logic      [`SBSC_DATA_W-1:0]   readData
);
  import sbsc_pkg::*;

  // no reset: contents survive reset and sleep alike
  logic [`SBSC_DATA_W-1:0] storage [0:`SBSC_DEPTH-1];

  always_ff @(posedge clk)
  begin
    if (writeEn)
    begin
      for (int i = 0; i < `SBSC_LANES; i++)
      begin
        if (laneEn[i])
        begin
          storage[addr][i*8 +: 8] <= writeData[i*8 +: 8];
        end
      end
    end
    else if (readEn)
    begin
      readData <= storage[addr];
    end
  end

endmodule

//--- rtl/sbsc_burst_counter.sv
// two-bit burst address counter, linear or interleaved
`timescale 1ns/1ps
module sbsc_burst_counter
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic       advance,
  input  wire logic [1:0] startIn,
  input  wire logic       linearMode,
  output logic      [1:0] curLow,
  output logic      [1:0] nextLow,
  output logic      [1:0] startOut,
  output logic      [1:0] stepOut
);
  import sbsc_pkg::*;

  logic [1:0] start_r;
  logic [1:0] step_r;
  logic [1:0] stepNext;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_r <= 2'h0;
      step_r  <= 2'h0;
    end
    else if (load)
    begin
      start_r <= startIn;
      step_r  <= 2'h0;
    end
    else if (advance)
    begin
      // step wraps modulo four, so the fifth address is the start again
      step_r <= stepNext;
    end
  end

  always_comb
  begin
    stepNext = 2'(step_r + 2'h1);
    curLow   = linearMode ? 2'(start_r + step_r) : (start_r ^ step_r);
    nextLow  = linearMode ? 2'(start_r + stepNext) : (start_r ^ stepNext);
  end

  assign startOut = start_r;
  assign stepOut  = step_r;

endmodule

//--- bench/sbsc_host_model.sv
// processor or cache controller model driving the synchronous memory pins
`timescale 1ns/1ps
`include "sbsc_map.svh"
module sbsc_host_model
(
  input  wire logic                    mclk,
  output logic [`SBSC_ADDR_W-1:0]      sramAddr,
  output sbsc_pkg::sbsc_pins_type      sramPins,
  output logic [`SBSC_DATA_W-1:0]      dqIn
);
  import sbsc_pkg::*;

  // idle is a deselect: first enable high with controller strobe low
  initial
  begin
    sramPins = 12'hb7f;
    sramAddr = 16'h0000;
    dqIn     = 32'h0000_0000;
  end

  // ==========================================
  // one bus cycle, launched right after an edge
  task automatic put(input sbsc_pins_type p, input logic [15:0] a, input logic [31:0] d,
                     input logic wr);
    @(posedge mclk);
    sramPins <= p;
    sramAddr <= a;
    // lines not driven for a write flip every cycle so stale data never looks valid
    dqIn     <= wr ? d : ~dqIn;
  endtask
endmodule

//--- bench/tb_sync_burst_sram_control.sv
// self-checking bench for the burst memory control block
`timescale 1ns/1ps
`include "sbsc_map.svh"
module tb_sync_burst_sram_control;
  import sbsc_pkg::*;
  logic             mclk;
  logic             sys_rst;
  logic             oeN;
  logic [15:0]      sramAddr;
  sbsc_pins_type    sramPins;
  sbsc_mode_type    modePins;
  logic [31:0]      dqIn;
  logic [31:0]      dqOut;
  logic [3:0]       dqOe;
  sbsc_axi_req_type axiReq;
  sbsc_axi_rsp_type axiRsp;
  int               numErrors;
  int               checks;
  logic [31:0]      seed;
  logic [31:0]      mem [8];
  logic [32:0]      cur;
  logic [32:0]      s0;
  logic [32:0]      s1;
  logic [13:0]      up [2];
  logic [13:0]      bUp;
  logic [1:0]       bStart;
  logic [1:0]       bStep;
  logic             chkOn;
  logic             sleepOn;
  logic [15:0]      accCnt;
  int               kinds [8] = '{2, 3, 3, 4, 1, 0, 5, 3};

  sbsc_control sbsc_control_inst (.mclk(mclk), .sys_rst(sys_rst), .sramAddr(sramAddr),
    .sramPins(sramPins), .modePins(modePins), .output_enable_n(oeN), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .axiReq(axiReq), .axiRsp(axiRsp));
  sbsc_host_model sbsc_host_model_inst (.mclk(mclk), .sramAddr(sramAddr),
    .sramPins(sramPins), .dqIn(dqIn));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] nextRand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (numErrors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // expected drive per cycle: {read, data}; pipelined output needs two reads in a row
  task automatic expOut(input logic [32:0] e);
    chk({28'h0, dqOe}, (e[32] && !oeN) ? 32'hf : 32'h0);
    if (e[32] && !oeN)
      chk(dqOut, e[31:0]);
  endtask

  always @(posedge mclk)
  begin
    s0 <= cur;
    s1 <= s0;
  end

  always @(negedge mclk)
    if (chkOn)
      expOut(modePins.output_register_select_n ? (s0[32] ? s1 : 33'h0) : s0);

  // ==========================================
  // register bus master
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    axiReq.awaddr  <= a;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (axiReq.awvalid && axiRsp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready)
        axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid)
      begin
        rs = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        return;
      end
    end
    numErrors++;
    stop_test();
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    axiReq.araddr  <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (axiReq.arvalid && axiRsp.arready)
        axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid)
      begin
        d = axiRsp.rdata;
        rs = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        return;
      end
    end
    numErrors++;
    stop_test();
  endtask

  // ==========================================
  // memory bus cycle: 0 deselect, 1/2 begin by processor/controller strobe,
  // 3 continue, 4 suspend, 5 begin with combined enable false
  task automatic op(input int k, input int wr, input logic [15:0] a, input logic [31:0] d,
                    input logic sl);
    sbsc_pins_type p;
    logic          w;
    logic          rd;
    logic          slp;
    logic [2:0]    ix;
    p = 12'h5ff;
    slp = sl | sleepOn;
    case (k)
      0: p = 12'hb7f;
      1: p.processor_addr_strobe_n = 1'b0;
      2: p.controller_addr_strobe_n = 1'b0;
      3: p.burst_advance_n = 1'b0;
      5: {p.processor_addr_strobe_n, p.chip_enable_high, p.chip_enable_third_n} =
           {1'b0, d[30], d[30] | d[29]};
      default: ;
    endcase
    if (k == 3 || k == 4)
      p.chip_enable_first_n = d[31];
    if (wr == 1)
      p.global_write_n = 1'b0;
    if (wr == 2)
      {p.byte_write_n, p[3:0]} = {1'b0, d[27:24]};
    w = (!p.global_write_n || (!p.byte_write_n && p[3:0] != 4'hf)) && k >= 2 && k <= 4 && !slp;
    rd = k != 0 && k != 5 && !w && !slp;
    if (rd || w)
      accCnt++;
    if (!slp && (k == 1 || k == 2))
      {bUp, bStart, bStep} = {a, 2'b00};
    if (!slp && k == 3)
      bStep++;
    ix = {bUp == up[1], modePins.burst_order_select_n ? bStart ^ bStep : bStart + bStep};
    for (int i = 0; i < 4; i++)
      if (w && (!p.global_write_n || !p[i]))
        mem[ix][8*i +: 8] = d[8*i +: 8];
    sbsc_host_model_inst.put(p, a, d, w);
    modePins.sleep_request <= sl;
    cur <= {rd, mem[ix]};
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] v;
    logic [31:0] r;
    logic [1:0]  rs;
    seed = 32'hf5a91165;
    sys_rst = 1'b1;
    oeN = 1'b0;
    modePins = 3'b110;
    axiReq = '0;
    cur = '0;
    numErrors = 0;
    checks = 0;
    chkOn = 1'b0;
    sleepOn = 1'b0;
    accCnt = 16'h0;
    v = nextRand();
    up[0] = v[13:0];
    up[1] = ~v[13:0];
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    chkOn <= 1'b1;
    axiRd(`SBSC_OFF_CTRL, v, rs);
    chk(v, 32'h0);
    chk({30'h0, rs}, {30'h0, `SBSC_RESP_OKAY});
    axiRd(8'h0c, v, rs);
    chk(v, 32'h0);
    chk({30'h0, rs}, {30'h0, `SBSC_RESP_SLVERR});
    // block 0 by single-cycle writes, block 1 by one write burst
    for (int s = 0; s < 2; s++)
      for (int j = 0; j < 4; j++)
        op((s == 0 || j == 0) ? 2 : 3, 1, {up[s], 2'(j)}, nextRand(), 1'b0);
    op(0, 0, 16'h0, 32'h0, 1'b0);
    // sleep forced by software: reads do nothing and the counter holds
    axiWr(`SBSC_OFF_CTRL, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, `SBSC_RESP_OKAY});
    sleepOn = 1'b1;
    op(3, 0, 16'h0, 32'h0, 1'b0);
    op(0, 0, 16'h0, 32'h0, 1'b0);
    axiRd(`SBSC_OFF_STATUS, v, rs);
    chk({31'h0, v[`SBSC_ST_ASLEEP]}, 32'h1);
    chk({29'h0, v[`SBSC_ST_STATE +: 3]}, 32'h5);
    axiWr(`SBSC_OFF_CTRL, 32'h0, rs);
    sleepOn = 1'b0;
    // every mode pair, modes switched only while deselected
    for (int m = 3; m >= 0; m--)
    begin
      // a full deselect edge first, so no burst step straddles the mode change
      op(0, 0, 16'h0, 32'h0, 1'b0);
      modePins[2:1] <= 2'(m);
      op(0, 0, 16'h0, 32'h0, 1'b0);
      for (int i = 0; i < 150; i++)
      begin
        r = nextRand();
        op(kinds[r[2:0]], r[9:8] % 3, {up[r[10]], r[12:11]}, nextRand(), r[16:13] == 0);
        oeN <= r[19:17] == 0;
      end
      oeN <= 1'b0;
      op(0, 0, 16'h0, 32'h0, 1'b0);
    end
    op(0, 0, 16'h0, 32'h0, 1'b0);
    axiRd(`SBSC_OFF_COUNT, v, rs);
    chk(v, {16'h0, accCnt});
    stop_test();
  end
endmodule
